// ==== bench/srw_master.sv ====
/*
 Far-side master model: drains answer bytes in order, can stall.
 Assumes the same clock as the core; the bench sends the requests.
*/
`timescale 1ns/10ps
module srw_master (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Answer stream
    input wire [7:0] tx_byte,
    input wire tx_valid,
    output wire tx_ready,
    // Bench control
    input wire stall
);
    logic [7:0] got [0:255];
    int n_got = 0;

    assign tx_ready = !stall;

    always @(posedge clk) begin
        if (rst) begin
            n_got <= 0;
        end else if (tx_valid && tx_ready) begin
            got[n_got[7:0]] <= tx_byte;
            n_got <= n_got + 1;
        end
    end
endmodule

// ==== bench/srw_props.sv ====
/*
 Concurrent checks on the ports of srw_core.
 Assumes it is bound to srw_core by the testbench, one clock, sync reset.
*/
`timescale 1ns/10ps
module srw_props #(
    parameter [15:0] KIND_CODE = 16'h0abc,
    parameter [31:0] SERIAL_NUMBER = 32'h00000001,
    parameter [15:0] FW_REVISION = 16'h0100
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Answer stream
    input wire [7:0] tx_byte,
    input wire tx_valid,
    input wire tx_ready,
    // Register read port
    input wire [15:0] rd_addr,
    input wire [15:0] rd_data,
    input wire rd_error,
    // Measurement engine
    input wire [7:0] app_code,
    input wire [7:0] type_code,
    input wire [7:0] cmd_code,
    input wire cmd_strobe,
    input wire [7:0] engine_state,
    input wire [7:0] meas_state
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ==========================================
    // Properties
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("answer byte changed before it was taken");
    chk_answer_head: assert property ($rose(tx_valid) |-> tx_byte inside {8'h10, 8'h90})
        else $error("answer starts with a wrong code");
    chk_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
        else $error("command strobe longer than one cycle");
    chk_cmd_legal: assert property (cmd_strobe |->
        cmd_code <= 8'h09 && !(cmd_code inside {8'h05, 8'h08}))
        else $error("illegal command issued");
    chk_app_range: assert property (app_code <= 8'h04)
        else $error("application code out of range");
    chk_type_range: assert property (type_code >= 8'h01 && type_code <= 8'h06)
        else $error("measurement type out of range");
    chk_state_copy: assert property (!$past(rst) |-> meas_state == $past(engine_state))
        else $error("state copy does not follow engine");
    chk_kind_word: assert property (rd_addr == 16'h1000 |=>
        rd_data == KIND_CODE && !rd_error)
        else $error("device kind word wrong");
    chk_serial_hi: assert property (rd_addr == 16'h1001 |=>
        rd_data == SERIAL_NUMBER[31:16])
        else $error("serial number high half wrong");
    chk_fw_word: assert property (rd_addr == 16'h1003 |=> rd_data == FW_REVISION)
        else $error("firmware word wrong");
    chk_app_word: assert property (rd_addr == 16'h2000 |=>
        rd_data == {8'h00, $past(app_code)})
        else $error("application word wrong");
    chk_unmapped_rd: assert property (rd_addr == 16'h3000 |=> rd_error)
        else $error("unmapped read not flagged");

    cover property (cmd_strobe);
    cover property (tx_valid && tx_ready && tx_byte == 8'h90);
    cover property (tx_valid && !tx_ready);
endmodule

// ==== bench/testbench.sv ====
/*
 Self-checking bench for srw_core: write requests, answers, register reads.
 Assumes srw_master.sv and srw_props.sv compiled before it.
*/
`timescale 1ns/10ps
module testbench;
    localparam [15:0] KIND = 16'h0abc; // Arbitrary value
    localparam [31:0] SN = 32'h12345678;
    localparam [15:0] FW = 16'h0203;
    logic clk, rst, rx_valid, rx_first, tx_valid, tx_ready, stall, zero_done;
    logic rd_error, cmd_strobe, busy;
    logic [7:0] rx_byte, tx_byte, app_code, type_code, cmd_code, engine_state, meas_state;
    logic [15:0] rd_addr, rd_data;
    logic [15:0] wv [0:127];
    logic [7:0] last_cmd;
    logic [7:0] cmds [0:6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h07, 8'h09};
    int n_mismatch = 0;
    int checks = 0;
    int n_strobe = 0;

    srw_core #(.KIND_CODE(KIND), .SERIAL_NUMBER(SN), .FW_REVISION(FW)) srw_core_i (
        .clk(clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_error(rd_error), .app_code(app_code), .type_code(type_code),
        .cmd_code(cmd_code), .cmd_strobe(cmd_strobe), .engine_state(engine_state),
        .zero_done(zero_done), .meas_state(meas_state), .busy(busy));
    srw_master srw_master_i (.clk(clk), .rst(rst), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .stall(stall));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (cmd_strobe === 1'b1) begin
            n_strobe <= n_strobe + 1;
            last_cmd <= cmd_code;
        end
    end

    // ==========================================
    // Compare and access tasks
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp16({8'h00, got}, {8'h00, exp});
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic err);
        @(posedge clk);
        #1 rd_addr = a;
        @(posedge clk);
        #1;
        if (!err) cmp16(rd_data, exp);
        cmp8({7'h00, rd_error}, {7'h00, err});
    endtask

    task automatic put(input logic [7:0] b, input logic first);
        @(posedge clk);
        #1 rx_byte = b;
        rx_valid = 1'b1;
        rx_first = first;
    endtask

    // Sends one request; exc of zero means a normal echo is expected
    task automatic xact(input logic [15:0] a, input logic [15:0] q, input logic [7:0] bc,
                        input logic [7:0] exc);
        int base;
        int k;
        logic [7:0] e [0:4];
        base = srw_master_i.n_got;
        put(8'h10, 1'b1);
        put(a[15:8], 1'b0);
        put(a[7:0], 1'b0);
        put(q[15:8], 1'b0);
        put(q[7:0], 1'b0);
        put(bc, 1'b0);
        for (k = 0; k < bc / 2; k++) begin
            put(wv[k][15:8], 1'b0);
            put(wv[k][7:0], 1'b0);
        end
        @(posedge clk);
        #1 rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_byte = ~rx_byte;
        cmp8({7'h00, busy}, 8'h01);
        e = '{8'h10, a[15:8], a[7:0], q[15:8], q[7:0]};
        if (exc != 8'h00) begin
            e[0] = 8'h90;
            e[1] = exc;
        end
        k = 0;
        while (srw_master_i.n_got < base + (exc == 8'h00 ? 5 : 2) && k < 2000) begin
            @(posedge clk);
            k++;
        end
        cmp16(16'(srw_master_i.n_got - base), (exc == 8'h00) ? 16'h0005 : 16'h0002);
        for (k = 0; k < (exc == 8'h00 ? 5 : 2); k++) begin
            cmp8(srw_master_i.got[base + k], e[k]);
        end
        repeat (3) @(posedge clk);
        #1;
        cmp8({6'h00, busy, tx_valid}, 8'h00);
    endtask

    task automatic err1(input logic [15:0] a, input logic [15:0] w, input logic [7:0] exc);
        wv[0] = w;
        xact(a, 16'h0001, 8'h02, exc);
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        $display("Watchdog expired at t=%0t", $time);
        end_sim();
    end

    // ==========================================
    // Tests
    initial begin
        rst = 1'b1;
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        rx_first = 1'b0;
        stall = 1'b0;
        zero_done = 1'b0;
        engine_state = 8'h00;
        rd_addr = 16'h0000;
        for (int i = 0; i < 128; i++) wv[i] = 16'h0000;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        rd(16'h2000, 16'h0000, 1'b0);
        rd(16'h2001, 16'h0001, 1'b0);
        rd(16'h1000, KIND, 1'b0);
        rd(16'h1001, SN[31:16], 1'b0);
        rd(16'h1002, SN[15:0], 1'b0);
        rd(16'h1003, FW, 1'b0);
        rd(16'h3000, 16'h0000, 1'b1);
        engine_state = 8'h0c;
        rd(16'h2002, 16'h000c, 1'b0);
        $display("Test reset and read map done");
        // Three contiguous words with a stalled master
        wv[0] = 16'h0004;
        wv[1] = 16'h0006;
        wv[2] = 16'h0000;
        stall = 1'b1;
        fork
            xact(16'h2000, 16'h0003, 8'h06, 8'h00);
            begin
                repeat (40) @(posedge clk);
                #1 stall = 1'b0;
            end
        join
        rd(16'h2000, 16'h0004, 1'b0);
        rd(16'h2001, 16'h0006, 1'b0);
        cmp8(last_cmd, 8'h00);
        $display("Test multi-word write done");
        err1(16'h2000, 16'h0005, 8'h04);
        err1(16'h2000, 16'h0100, 8'h04);
        err1(16'h2001, 16'h0000, 8'h04);
        err1(16'h2001, 16'h0007, 8'h04);
        err1(16'h1000, 16'h1234, 8'h04);
        err1(16'h1002, 16'h0000, 8'h04);
        err1(16'h1003, 16'h0000, 8'h04);
        err1(16'h2002, 16'h0005, 8'h04);
        err1(16'h2002, 16'h0008, 8'h04);
        err1(16'h2002, 16'h000a, 8'h04);
        err1(16'h3000, 16'h0000, 8'h02);
        xact(16'h2000, 16'h0000, 8'h00, 8'h03);
        xact(16'h2000, 16'h007c, 8'h00, 8'h03);
        xact(16'h2000, 16'h0002, 8'h02, 8'h03);
        xact(16'h2000, 16'h007b, 8'hf6, 8'h02);
        rd(16'h2000, 16'h0004, 1'b0);
        rd(16'h2001, 16'h0006, 1'b0);
        rd(16'h1000, KIND, 1'b0);
        cmp16(n_strobe[15:0], 16'h0001);
        $display("Test refused writes done");
        for (int i = 0; i < 7; i++) begin
            err1(16'h2002, {8'h00, cmds[i]}, 8'h00);
            cmp8(last_cmd, cmds[i]);
            cmp16(n_strobe[15:0], 16'(i + 2));
        end
        err1(16'h2002, 16'h0003, 8'h00);
        cmp8(last_cmd, 8'h03);
        zero_done = 1'b1;
        err1(16'h2002, 16'h0003, 8'h00);
        cmp16(n_strobe[15:0], 16'h0009);
        $display("Test commands done");
        end_sim();
    end
endmodule

bind srw_core srw_props #(.KIND_CODE(KIND_CODE), .SERIAL_NUMBER(SERIAL_NUMBER),
    .FW_REVISION(FW_REVISION)) srw_props_i (.clk(clk), .rst(rst), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_error(rd_error), .app_code(app_code), .type_code(type_code), .cmd_code(cmd_code),
    .cmd_strobe(cmd_strobe), .engine_state(engine_state), .meas_state(meas_state));

// ==== logic/srw_core.v ====
/*
 Server-side handler for the write-multiple-registers request and its
 register map (identification and measurement control words).
 Assumes the UART framing, parity and address filtering stand outside:
 request bytes arrive one per strobe from logic on the same clock, the
 start of a request marked, and answer bytes leave through a valid/ready
 stream that the UART transmitter drains.
*/
// How it works
// - Function 0x10 writes 1 to 123 contiguous registers from the start address.
// - Success answer echoes function, start address and quantity.
// - Failure answer is 0x90 then one exception code 0x01 to 0x04.
// - Writes to identification words fail with code 4, nothing changes.
// - Register 0x1000 returns a fixed device-kind word.
// - Serial number high half at 0x1001, low half at 0x1002.
// - Register 0x1003: major revision high byte, minor low byte.
// - Register 0x2000 holds application 0 to 4; other codes fail.
// - Register 0x2001 holds type 1 to 6; others fail with code 4.
// - Reading 0x2002 returns current measurement state code up to 0x0c.
// - Writing 0x2002: 0 starts, 1 stops keeping, 2 stops discarding.
// - Command 3 zeros if needed, 6 always, 9 zeros pressure live.
// - Command 4 flushes until clean; 7 flushes until stopped.
// - No measurement programs; every mode is a free single measurement.
// - Erroneous write content answers with exception code 4.
// - Multi-byte fields travel high byte first; bytes sit in low half.
// - Link is 9600 baud, 8 data bits, even parity, one stop bit.
`timescale 1ns/10ps
`include "srw_defines.vh"
module srw_core #(
    parameter [15:0] KIND_CODE = 16'h0abc,
    parameter [31:0] SERIAL_NUMBER = 32'h00000001,
    parameter [15:0] FW_REVISION = 16'h0100
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Request bytes from the UART receiver
    input wire [7:0] rx_byte,
    input wire rx_valid,
    input wire rx_first,
    // Answer bytes to the UART transmitter
    output reg [7:0] tx_byte,
    output reg tx_valid,
    input wire tx_ready,
    // Register read port
    input wire [15:0] rd_addr,
    output reg [15:0] rd_data,
    output reg rd_error,
    // Measurement engine
    output reg [7:0] app_code,
    output reg [7:0] type_code,
    output reg [7:0] cmd_code,
    output reg cmd_strobe,
    input wire [7:0] engine_state,
    input wire zero_done,
    output reg [7:0] meas_state,
    output reg busy
);
    // ==========================================================
    // States
    localparam [5:0] S_FUNC = 6'b000001;
    localparam [5:0] S_HDR = 6'b000010;
    localparam [5:0] S_DATA = 6'b000100;
    localparam [5:0] S_COMMIT = 6'b001000;
    localparam [5:0] S_ANSWER = 6'b010000;
    localparam [5:0] S_SKIP = 6'b100000;

    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg [2:0] hdr_cnt_reg;
    reg [15:0] start_reg;
    reg [15:0] qty_reg;
    reg [7:0] bcnt_reg;
    reg [7:0] data_cnt_reg;
    reg [7:0] hi_byte_reg;
    reg [7:0] exc_reg;
    reg [7:0] new_app_reg;
    reg [7:0] new_type_reg;
    reg [7:0] new_cmd_reg;
    reg app_wr_reg;
    reg type_wr_reg;
    reg cmd_wr_reg;
    reg [2:0] ans_idx_reg;
    reg [2:0] ans_len_reg;
    reg [7:0] ans_byte;
    wire [15:0] word_addr;
    wire [15:0] word_val;
    wire [7:0] fifo_data;
    wire fifo_valid;
    wire fifo_in_ready;
    wire fifo_pop;
    reg [7:0] cmd_effect;

    // ==========================================================
    // Address classes
    function is_ident;
        input [15:0] a;
        begin
            is_ident = (a == `SRW_ADDR_KIND) || (a == `SRW_ADDR_SN_HI) ||
                (a == `SRW_ADDR_SN_LO) || (a == `SRW_ADDR_FW);
        end
    endfunction

    function is_ctrl;
        input [15:0] a;
        begin
            is_ctrl = (a == `SRW_ADDR_APP) || (a == `SRW_ADDR_TYPE) ||
                (a == `SRW_ADDR_STATE);
        end
    endfunction

    function cmd_ok;
        input [7:0] c;
        begin
            cmd_ok = (c == `SRW_CMD_BEGIN_MEASURE) || (c == `SRW_CMD_HALT_KEEP) ||
                (c == `SRW_CMD_HALT_DISCARD) || (c == `SRW_CMD_ZERO_CONDITIONAL) ||
                (c == `SRW_CMD_FLUSH_AUTO) || (c == `SRW_CMD_ZERO_ALWAYS) ||
                (c == `SRW_CMD_FLUSH_ENDLESS) || (c == `SRW_CMD_PRESSURE_ZERO_LIVE);
        end
    endfunction

    // Values arrive high byte first; address of the word now completing
    assign word_addr = start_reg + {9'h000, data_cnt_reg[7:1]};
    assign word_val = {hi_byte_reg, rx_byte};

    // ==========================================================
    // Request parser
    always @* begin
        state_next = state_reg;
        case (state_reg)
            S_FUNC: begin
                if (rx_valid && rx_first) begin
                    state_next = S_HDR;
                end
            end
            S_HDR: begin
                if (rx_valid && hdr_cnt_reg == 3'd4) begin
                    state_next = (rx_byte == 8'h00) ? S_COMMIT : S_DATA;
                end
            end
            S_DATA: begin
                if (rx_valid && data_cnt_reg == bcnt_reg - 8'h01) begin
                    state_next = S_COMMIT;
                end
            end
            S_COMMIT: begin
                state_next = S_ANSWER;
            end
            S_ANSWER: begin
                if (fifo_in_ready && ans_idx_reg == ans_len_reg) begin
                    state_next = S_FUNC;
                end
            end
            S_SKIP: begin
                state_next = S_ANSWER;
            end
            default: begin
                state_next = S_FUNC;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_reg <= S_FUNC;
            hdr_cnt_reg <= 3'd0;
            start_reg <= 16'h0000;
            qty_reg <= 16'h0000;
            bcnt_reg <= 8'h00;
            data_cnt_reg <= 8'h00;
            hi_byte_reg <= 8'h00;
            exc_reg <= 8'h00;
            new_app_reg <= `SRW_APP_RESET;
            new_type_reg <= `SRW_TYPE_RESET;
            new_cmd_reg <= 8'h00;
            app_wr_reg <= 1'b0;
            type_wr_reg <= 1'b0;
            cmd_wr_reg <= 1'b0;
            ans_idx_reg <= 3'd0;
            ans_len_reg <= 3'd0;
        end else begin
            state_reg <= state_next;
            case (state_reg)
                S_FUNC: begin
                    hdr_cnt_reg <= 3'd0;
                    data_cnt_reg <= 8'h00;
                    app_wr_reg <= 1'b0;
                    type_wr_reg <= 1'b0;
                    cmd_wr_reg <= 1'b0;
                    ans_idx_reg <= 3'd0;
                    // Any other function answers illegal function
                    if (rx_valid && rx_first) begin
                        exc_reg <= (rx_byte == `SRW_FC_WRITE) ? 8'h00 :
                            `SRW_EXC_ILLEGAL_FUNC;
                    end
                end
                S_HDR: begin
                    if (rx_valid) begin
                        hdr_cnt_reg <= hdr_cnt_reg + 3'd1;
                        case (hdr_cnt_reg)
                            3'd0: start_reg[15:8] <= rx_byte;
                            3'd1: start_reg[7:0] <= rx_byte;
                            3'd2: qty_reg[15:8] <= rx_byte;
                            3'd3: qty_reg[7:0] <= rx_byte;
                            default: begin
                                bcnt_reg <= rx_byte;
                                // Quantity range and byte count check
                                if (exc_reg == 8'h00 && (qty_reg < `SRW_QTY_MIN ||
                                    qty_reg > `SRW_QTY_MAX ||
                                    {8'h00, rx_byte} != {qty_reg[14:0], 1'b0})) begin
                                    exc_reg <= `SRW_EXC_ILLEGAL_VALUE;
                                end
                            end
                        endcase
                    end
                end
                S_DATA: begin
                    if (rx_valid) begin
                        data_cnt_reg <= data_cnt_reg + 8'h01;
                        if (!data_cnt_reg[0]) begin
                            hi_byte_reg <= rx_byte;
                        end else if (exc_reg == 8'h00) begin
                            if (is_ident(word_addr)) begin
                                exc_reg <= `SRW_EXC_DEVICE_FAIL;
                            end else if (!is_ctrl(word_addr)) begin
                                exc_reg <= `SRW_EXC_ILLEGAL_ADDR;
                            end else if (hi_byte_reg != 8'h00) begin
                                exc_reg <= `SRW_EXC_DEVICE_FAIL;
                            end else if (word_addr == `SRW_ADDR_APP) begin
                                if (rx_byte > `SRW_APP_MAX) begin
                                    exc_reg <= `SRW_EXC_DEVICE_FAIL;
                                end else begin
                                    new_app_reg <= word_val[7:0];
                                    app_wr_reg <= 1'b1;
                                end
                            end else if (word_addr == `SRW_ADDR_TYPE) begin
                                if (rx_byte < `SRW_TYPE_MIN || rx_byte > `SRW_TYPE_MAX) begin
                                    exc_reg <= `SRW_EXC_DEVICE_FAIL;
                                end else begin
                                    new_type_reg <= word_val[7:0];
                                    type_wr_reg <= 1'b1;
                                end
                            end else if (!cmd_ok(rx_byte)) begin
                                exc_reg <= `SRW_EXC_DEVICE_FAIL;
                            end else begin
                                new_cmd_reg <= rx_byte;
                                cmd_wr_reg <= 1'b1;
                            end
                        end
                    end
                end
                S_COMMIT: begin
                    ans_len_reg <= (exc_reg != 8'h00) ? 3'd1 : 3'd4;
                end
                S_ANSWER: begin
                    if (fifo_in_ready) begin
                        ans_idx_reg <= ans_idx_reg + 3'd1;
                    end
                end
                default: begin
                    hdr_cnt_reg <= 3'd0;
                end
            endcase
        end
    end

    // ==========================================================
    // Answer bytes, high byte first
    always @* begin
        case (ans_idx_reg)
            3'd0: ans_byte = (exc_reg != 8'h00) ? (`SRW_FC_WRITE | `SRW_FC_ERR_BIT) :
                `SRW_FC_WRITE;
            3'd1: ans_byte = (exc_reg != 8'h00) ? exc_reg : start_reg[15:8];
            3'd2: ans_byte = start_reg[7:0];
            3'd3: ans_byte = qty_reg[15:8];
            3'd4: ans_byte = qty_reg[7:0];
            default: ans_byte = 8'h00;
        endcase
    end

    srw_fifo #(
        .WIDTH(`SRW_FIFO_WIDTH),
        .DEPTH(`SRW_FIFO_DEPTH),
        .AW(`SRW_FIFO_AW)
    ) u_tx_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(ans_byte),
        .in_valid(state_reg == S_ANSWER),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // Output stage register; reloads when empty or taken
    assign fifo_pop = fifo_valid && (!tx_valid || tx_ready);

    always @(posedge clk) begin
        if (rst) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
        end else if (fifo_pop) begin
            tx_valid <= 1'b1;
            tx_byte <= fifo_data;
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // ==========================================================
    // Control words, committed only when the whole request is clean
    always @* begin
        cmd_effect = new_cmd_reg;
        // Conditional zeroing is skipped once zeroing is done
        if (new_cmd_reg == `SRW_CMD_ZERO_CONDITIONAL && zero_done) begin
            cmd_effect = `SRW_CMD_BEGIN_MEASURE;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            app_code <= `SRW_APP_RESET;
            type_code <= `SRW_TYPE_RESET;
            cmd_code <= 8'h00;
            cmd_strobe <= 1'b0;
            meas_state <= `SRW_ST_UNINITIALIZED;
            busy <= 1'b0;
            rd_data <= 16'h0000;
            rd_error <= 1'b0;
        end else begin
            cmd_strobe <= 1'b0;
            busy <= (state_reg != S_FUNC);
            meas_state <= engine_state;
            if (state_reg == S_COMMIT && exc_reg == 8'h00) begin
                if (app_wr_reg) begin
                    app_code <= new_app_reg;
                end
                if (type_wr_reg) begin
                    type_code <= new_type_reg;
                end
                if (cmd_wr_reg && !(new_cmd_reg == `SRW_CMD_ZERO_CONDITIONAL && zero_done)) begin
                    cmd_code <= cmd_effect;
                    cmd_strobe <= 1'b1;
                end
            end
            rd_error <= !(is_ident(rd_addr) || is_ctrl(rd_addr));
            case (rd_addr)
                `SRW_ADDR_KIND: rd_data <= KIND_CODE;
                `SRW_ADDR_SN_HI: rd_data <= SERIAL_NUMBER[31:16];
                `SRW_ADDR_SN_LO: rd_data <= SERIAL_NUMBER[15:0];
                `SRW_ADDR_FW: rd_data <= FW_REVISION;
                `SRW_ADDR_APP: rd_data <= {8'h00, app_code};
                `SRW_ADDR_TYPE: rd_data <= {8'h00, type_code};
                `SRW_ADDR_STATE: rd_data <= {8'h00, meas_state};
                default: rd_data <= 16'h0000;
            endcase
        end
    end
endmodule

// ==== logic/srw_defines.vh ====
/*
 Constants for the write-registers handler: protocol codes, register
 addresses, field codes and state codes. Included by the core design file only.
*/
`ifndef SRW_DEFINES_VH
`define SRW_DEFINES_VH

`define SRW_FC_WRITE 8'h10
`define SRW_FC_ERR_BIT 8'h80
`define SRW_EXC_ILLEGAL_FUNC 8'h01
`define SRW_EXC_ILLEGAL_ADDR 8'h02
`define SRW_EXC_ILLEGAL_VALUE 8'h03
`define SRW_EXC_DEVICE_FAIL 8'h04
`define SRW_QTY_MIN 16'h0001
`define SRW_QTY_MAX 16'h007b

`define SRW_ADDR_KIND 16'h1000
`define SRW_ADDR_SN_HI 16'h1001
`define SRW_ADDR_SN_LO 16'h1002
`define SRW_ADDR_FW 16'h1003
`define SRW_ADDR_APP 16'h2000
`define SRW_ADDR_TYPE 16'h2001
`define SRW_ADDR_STATE 16'h2002

`define SRW_APP_MAX 8'h04
`define SRW_TYPE_MIN 8'h01
`define SRW_TYPE_MAX 8'h06
`define SRW_APP_RESET 8'h00
`define SRW_TYPE_RESET 8'h01

`define SRW_CMD_BEGIN_MEASURE 8'h00
`define SRW_CMD_HALT_KEEP 8'h01
`define SRW_CMD_HALT_DISCARD 8'h02
`define SRW_CMD_ZERO_CONDITIONAL 8'h03
`define SRW_CMD_FLUSH_AUTO 8'h04
`define SRW_CMD_ZERO_ALWAYS 8'h06
`define SRW_CMD_FLUSH_ENDLESS 8'h07
`define SRW_CMD_PRESSURE_ZERO_LIVE 8'h09

`define SRW_ST_UNINITIALIZED 8'h00
`define SRW_ST_IDLE 8'h01
`define SRW_ST_RUNNING 8'h02
`define SRW_ST_ZEROING 8'h03
`define SRW_ST_FLUSHING 8'h04
`define SRW_ST_WAIT_EXIT 8'h0c

`define SRW_FIFO_WIDTH 8
`define SRW_FIFO_DEPTH 8
`define SRW_FIFO_AW 3

`endif

// ==== logic/srw_fifo.v ====
/*
 Synchronous FIFO of flip-flops with valid/ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module srw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fill side
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    integer i;

    assign in_ready = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_reg[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
